//--- verilog/dfa_pkg.sv
// Purpose: Shared constants and token layouts for the dataflow bus actors.
// Assumes: Word-addressed bus, 32-bit data, single clock.
// Notes:   Struct layouts are shared by the top module and the bench.

// ****************************************************************
// Package
// ****************************************************************
package dfa_pkg;

    // Bus geometry
    localparam int ADR_W  = 30;
    localparam int DAT_W  = 32;
    localparam int SEL_W  = 4;

    // Classic cycle type, all lanes selected
    localparam logic [2:0]       CTI_CLASSIC = 3'h0;
    localparam logic [SEL_W-1:0] SEL_ALL     = 4'hf;

    // Depth of the read-return buffer
    localparam int RD_FIFO_DEPTH = 16;

    // Reset values
    localparam logic [ADR_W-1:0] ADR_RST = 30'h0;
    localparam logic [DAT_W-1:0] DAT_RST = 32'h0;

    // Writer token: address plus data
    typedef struct packed {
        logic [ADR_W-1:0] adr;
        logic [DAT_W-1:0] dat;
    } dfa_wr_tok_t;

    // Bus request from one master
    typedef struct packed {
        logic             cyc;
        logic             stb;
        logic             we;
        logic [ADR_W-1:0] adr;
        logic [DAT_W-1:0] dat;
        logic [SEL_W-1:0] sel;
        logic [2:0]       cti;
    } dfa_wb_req_t;

    // Bus response to one master
    typedef struct packed {
        logic             ack;
        logic             stall;
        logic [DAT_W-1:0] dat;
    } dfa_wb_rsp_t;

    // Sequence generator states, one-hot
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_RUN  = 2'b10
    } dfa_seq_state_t;

endpackage : dfa_pkg

//--- verilog/dfa_top.sv
// Purpose: Dataflow bus actors: bus reader, bus writer, integer sequencer.
// Assumes: Bus slave on the same clock, pipelined signalling with stall.
// Notes:   Reader returns words through a 16-entry buffer in token order.

`timescale 1ns/1ps

// ****************************************************************
// Buffer
// ****************************************************************
module dfa_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst_b,
    // Fill side
    input  wire logic                     in_valid,
    output logic                          in_ready,
    input  wire logic [WIDTH-1:0]         in_data,
    // Drain side
    output logic                          out_valid,
    input  wire logic                     out_ready,
    output logic [WIDTH-1:0]              out_data,
    // Fill level
    output logic [$clog2(DEPTH):0]        count
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    // Handshakes; full and empty straight from the level
    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_q[rd_q];
    assign count     = cnt_q;

    // Pointer and level next values
    always_comb begin
        wr_d  = push ? wr_q + AW'(1) : wr_q;
        rd_d  = pop ? rd_q + AW'(1) : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Pointer registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage, one slot per index; no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule : dfa_fifo

// ****************************************************************
// Top
// ****************************************************************
// Summary of operation
// RL1: Each accepted address token yields one 32-bit read word token.
// RL2: Reader issues single classic cycles only, no bursts, no read cache.
// RL3: Reader is pipelined; only slave stalls and free read-buffer space limit its throughput.
// RL4: Each accepted address-plus-data token writes that word at that address.
// RL5: Writer issues single classic cycles only, never bursts.
// RL6: Writer adds no idle cycles; only slave stalls limit throughput.
// RL7: Count N without offset emits values 0 through N-1.
// RL8: With offset O, emits O through O+N-1, one per token.
// RL9: Count width parameter sets count field and value widths.
// RL10: Offset width parameter; zero (default) means no offset field used.
// RL11: Transfer when valid and accept both high; source holds until taken.
// RL12: Accepts may follow valids combinationally, never valid from accept.
// RL13: Busy is high while state remains that still leads to output.
// RL14: Sequencer counts upward and takes a new token only when done.
// RL15: Read words leave in the order their addresses were accepted.
module dfa_top
    import dfa_pkg::*;
#(
    parameter int CNT_W   = 16,
    parameter int OFS_W   = 0,
    parameter int RD_DEPTH = RD_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                      CLOCK_IN,
    input  wire logic                      RST_B_IN,
    // Reader address sink
    input  wire logic                      RD_ADR_VALID_IN,
    output logic                           RD_ADR_READY_OUT,
    input  wire logic [dfa_pkg::ADR_W-1:0] RD_ADR_IN,
    // Reader data source
    output logic                           RD_DAT_VALID_OUT,
    input  wire logic                      RD_DAT_READY_IN,
    output logic [dfa_pkg::DAT_W-1:0]      RD_DAT_OUT,
    // Reader bus master
    output dfa_pkg::dfa_wb_req_t           RD_WB_REQ_OUT,
    input  dfa_pkg::dfa_wb_rsp_t           RD_WB_RSP_IN,
    // Writer token sink
    input  wire logic                      WR_TOK_VALID_IN,
    output logic                           WR_TOK_READY_OUT,
    input  dfa_pkg::dfa_wr_tok_t           WR_TOK_IN,
    // Writer bus master
    output dfa_pkg::dfa_wb_req_t           WR_WB_REQ_OUT,
    input  dfa_pkg::dfa_wb_rsp_t           WR_WB_RSP_IN,
    // Sequencer token sink
    input  wire logic                      SEQ_CMD_VALID_IN,
    output logic                           SEQ_CMD_READY_OUT,
    input  wire logic [CNT_W-1:0]          SEQ_CNT_IN,
    input  wire logic [(OFS_W>0?OFS_W:1)-1:0] SEQ_OFS_IN,
    // Sequencer value source
    output logic                           SEQ_VAL_VALID_OUT,
    input  wire logic                      SEQ_VAL_READY_IN,
    output logic [((OFS_W>CNT_W?OFS_W:CNT_W)+(OFS_W>0?1:0))-1:0] SEQ_VAL_OUT,
    // Busy flags
    output logic                           RD_BUSY_OUT,
    output logic                           WR_BUSY_OUT,
    output logic                           SEQ_BUSY_OUT
);
    localparam int FC_W  = $clog2(RD_DEPTH) + 1;
    localparam int VAL_W = (OFS_W > CNT_W ? OFS_W : CNT_W) + (OFS_W > 0 ? 1 : 0);

    // ************************************************************
    // Reader
    // ************************************************************
    logic [FC_W-1:0] rd_out_q, rd_out_d;
    logic [FC_W-1:0] rd_fill;
    logic            rd_credit, rd_issue, rd_fifo_in_ready;

    // Credit covers words in flight plus words buffered, so acks never overflow.
    // The slave cannot be told to hold an ack, so space is reserved at issue
    // time; the buffer's own ready only backs this up.
    assign rd_credit = rd_fifo_in_ready && ((rd_out_q + rd_fill) < FC_W'(RD_DEPTH));

    // Bus strobe follows the token valid; no path back from our accept
    always_comb begin
        RD_WB_REQ_OUT.stb = RD_ADR_VALID_IN && rd_credit;              // RL12
        RD_WB_REQ_OUT.cyc = RD_WB_REQ_OUT.stb || (rd_out_q != '0);
        RD_WB_REQ_OUT.we  = 1'b0;
        RD_WB_REQ_OUT.adr = RD_ADR_IN;                                  // RL1
        RD_WB_REQ_OUT.dat = DAT_RST;
        RD_WB_REQ_OUT.sel = SEL_ALL;
        RD_WB_REQ_OUT.cti = CTI_CLASSIC;                                // RL2
    end

    // Token taken the cycle the slave takes the request
    assign rd_issue         = RD_WB_REQ_OUT.stb && !RD_WB_RSP_IN.stall; // RL3
    assign RD_ADR_READY_OUT = rd_issue;                                 // RL11

    // Outstanding reads
    always_comb begin
        rd_out_d = rd_out_q + FC_W'(rd_issue) - FC_W'(RD_WB_RSP_IN.ack);
    end

    // Outstanding read register
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_B_IN) begin
            rd_out_q <= '0;
        end else begin
            rd_out_q <= rd_out_d;
        end
    end

    // Returned words queue in arrival order; slave answers in order
    dfa_fifo #(
        .WIDTH (DAT_W),
        .DEPTH (RD_DEPTH)
    ) u_rd_fifo (
        .clk       (CLOCK_IN),
        .rst_b     (RST_B_IN),
        .in_valid  (RD_WB_RSP_IN.ack),
        .in_ready  (rd_fifo_in_ready),
        .in_data   (RD_WB_RSP_IN.dat),
        .out_valid (RD_DAT_VALID_OUT),
        .out_ready (RD_DAT_READY_IN),
        .out_data  (RD_DAT_OUT),
        .count     (rd_fill)
    );                                                                  // RL15

    // Busy while reads are in flight or words wait
    assign RD_BUSY_OUT = (rd_out_q != '0) || RD_DAT_VALID_OUT;         // RL13

    // ************************************************************
    // Writer
    // ************************************************************
    logic [FC_W-1:0] wr_out_q, wr_out_d;
    logic            wr_issue;

    // Each token drives the bus directly, so back-to-back tokens stream
    always_comb begin
        WR_WB_REQ_OUT.stb = WR_TOK_VALID_IN;                            // RL6
        WR_WB_REQ_OUT.cyc = WR_TOK_VALID_IN || (wr_out_q != '0);
        WR_WB_REQ_OUT.we  = 1'b1;
        WR_WB_REQ_OUT.adr = WR_TOK_IN.adr;                              // RL4
        WR_WB_REQ_OUT.dat = WR_TOK_IN.dat;                              // RL4
        WR_WB_REQ_OUT.sel = SEL_ALL;
        WR_WB_REQ_OUT.cti = CTI_CLASSIC;                                // RL5
    end

    // Token accepted the cycle the slave takes the write
    assign wr_issue         = WR_TOK_VALID_IN && !WR_WB_RSP_IN.stall;
    assign WR_TOK_READY_OUT = wr_issue;                                 // RL11

    // Outstanding writes; no wrap guard, so the slave must keep fewer
    // than 2**FC_W writes unanswered
    always_comb begin
        wr_out_d = wr_out_q + FC_W'(wr_issue) - FC_W'(WR_WB_RSP_IN.ack);
    end

    // Outstanding write register
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_B_IN) begin
            wr_out_q <= '0;
        end else begin
            wr_out_q <= wr_out_d;
        end
    end

    // Busy until every write has been answered
    assign WR_BUSY_OUT = (wr_out_q != '0);                              // RL13

    // ************************************************************
    // Sequence generator
    // ************************************************************
    // State, current value and values left to hand out; with an offset the value carries one
    // bit above the wider of count and offset so that O+N-1 always fits
    dfa_seq_state_t   seq_st_q, seq_st_d;
    logic [VAL_W-1:0] seq_val_q, seq_val_d;
    logic [CNT_W-1:0] seq_rem_q, seq_rem_d;
    logic [VAL_W-1:0] seq_base;
    logic             seq_take, seq_give;

    // Offset ignored entirely when its width is zero
    generate
        if (OFS_W > 0) begin : g_ofs
            assign seq_base = VAL_W'(SEQ_OFS_IN);                       // RL8
        end else begin : g_no_ofs
            assign seq_base = '0;                                       // RL10
        end
    endgenerate

    // Input taken only while idle; output valid is pure state,
    // so no accept ever reaches a valid combinationally
    assign SEQ_CMD_READY_OUT = (seq_st_q == SEQ_IDLE);                  // RL14
    assign SEQ_VAL_VALID_OUT = (seq_st_q == SEQ_RUN);                   // RL12
    assign SEQ_VAL_OUT       = seq_val_q;                               // RL9
    assign SEQ_BUSY_OUT      = (seq_st_q == SEQ_RUN);                   // RL13
    assign seq_take          = SEQ_CMD_VALID_IN && SEQ_CMD_READY_OUT;
    assign seq_give          = SEQ_VAL_VALID_OUT && SEQ_VAL_READY_IN;

    // Next state; a count of zero emits nothing and stays idle
    always_comb begin
        seq_st_d  = seq_st_q;
        seq_val_d = seq_val_q;
        seq_rem_d = seq_rem_q;
        case (seq_st_q)
            SEQ_IDLE: begin
                if (seq_take && (SEQ_CNT_IN != '0)) begin
                    seq_st_d  = SEQ_RUN;
                    seq_val_d = seq_base;                               // RL7
                    seq_rem_d = SEQ_CNT_IN;
                end
            end
            SEQ_RUN: begin
                if (seq_give) begin
                    seq_val_d = seq_val_q + VAL_W'(1);                  // RL14
                    seq_rem_d = seq_rem_q - CNT_W'(1);
                    if (seq_rem_q == CNT_W'(1)) begin
                        seq_st_d = SEQ_IDLE;                            // RL8
                    end
                end
            end
            default: begin
                seq_st_d = SEQ_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_B_IN) begin
            seq_st_q  <= SEQ_IDLE;
            seq_val_q <= '0;
            seq_rem_q <= '0;
        end else begin
            seq_st_q  <= seq_st_d;
            seq_val_q <= seq_val_d;
            seq_rem_q <= seq_rem_d;
        end
    end
endmodule : dfa_top

//--- verification/dfa_wb_slave_model.sv
// Purpose: Pipelined bus slave standing in for system memory.
// Assumes: Same clock as the actors; acks strictly in issue order.
// Notes:   Read word is the address with 2'b01 appended.
`timescale 1ns/1ps
// ****************************************************************
// Slave model
// ****************************************************************
module dfa_wb_slave_model
    import dfa_pkg::*;
(
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst_b,
    // Bus side
    input  wire logic            stall_en,
    input  dfa_pkg::dfa_wb_req_t req,
    output dfa_pkg::dfa_wb_rsp_t rsp,
    // Write log
    output logic [7:0]           wr_cnt,
    output dfa_pkg::dfa_wr_tok_t wr_last
);
    logic             take;
    logic             ack_q;
    logic [DAT_W-1:0] dat_q;
    // Stall comes from the bench only, never from the request
    assign take = req.cyc & req.stb & ~stall_en;
    assign rsp  = '{ack: ack_q, stall: stall_en, dat: dat_q};
    // Idle data is inverted each cycle so stale words never match
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ack_q   <= 1'b0;
            dat_q   <= '0;
            wr_cnt  <= 8'h0;
            wr_last <= '0;
        end else begin
            ack_q <= take;
            dat_q <= (take & ~req.we) ? {req.adr, 2'b01} : ~dat_q;
            if (take & req.we) begin
                wr_cnt  <= wr_cnt + 8'h1;
                wr_last <= '{adr: req.adr, dat: req.dat};
            end
        end
    end
endmodule : dfa_wb_slave_model

//--- verification/dfa_top_asserts.sv
// Purpose: Port-level checks for the dataflow bus actors.
// Assumes: Single clock, synchronous active-low reset.
// Notes:   Bound into every dfa_top instance.
`timescale 1ns/1ps
// ****************************************************************
// Checker
// ****************************************************************
module dfa_top_chk
    import dfa_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int OFS_W = 0
) (
    // Clock and reset
    input  wire logic                 CLOCK_IN,
    input  wire logic                 RST_B_IN,
    // Reader
    input  wire logic                 RD_ADR_READY_OUT,
    input  wire logic [ADR_W-1:0]     RD_ADR_IN,
    input  wire logic                 RD_DAT_VALID_OUT,
    input  wire logic                 RD_DAT_READY_IN,
    input  wire logic [DAT_W-1:0]     RD_DAT_OUT,
    input  dfa_pkg::dfa_wb_req_t      RD_WB_REQ_OUT,
    input  dfa_pkg::dfa_wb_rsp_t      RD_WB_RSP_IN,
    input  wire logic                 RD_BUSY_OUT,
    // Writer
    input  wire logic                 WR_TOK_VALID_IN,
    input  wire logic                 WR_TOK_READY_OUT,
    input  dfa_pkg::dfa_wr_tok_t      WR_TOK_IN,
    input  dfa_pkg::dfa_wb_req_t      WR_WB_REQ_OUT,
    input  dfa_pkg::dfa_wb_rsp_t      WR_WB_RSP_IN,
    // Sequencer
    input  wire logic                 SEQ_CMD_VALID_IN,
    input  wire logic                 SEQ_CMD_READY_OUT,
    input  wire logic [CNT_W-1:0]     SEQ_CNT_IN,
    input  wire logic [(OFS_W>0?OFS_W:1)-1:0] SEQ_OFS_IN,
    input  wire logic                 SEQ_VAL_VALID_OUT,
    input  wire logic                 SEQ_VAL_READY_IN,
    input  wire logic [((OFS_W>CNT_W?OFS_W:CNT_W)+(OFS_W>0?1:0))-1:0] SEQ_VAL_OUT,
    input  wire logic                 SEQ_BUSY_OUT
);
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RST_B_IN);
    // A value handed over, then the next one showing
    sequence s_beat;
        SEQ_VAL_VALID_OUT && SEQ_VAL_READY_IN;
    endsequence
    sequence s_next;
        s_beat ##1 SEQ_VAL_VALID_OUT;
    endsequence
    rd_issue_a: assert property (
        RD_ADR_READY_OUT |-> RD_WB_REQ_OUT.stb && RD_WB_REQ_OUT.cyc && !RD_WB_RSP_IN.stall
        && RD_WB_REQ_OUT.adr == RD_ADR_IN) else $error("read issue mismatch");
    rd_classic_a: assert property (
        RD_WB_REQ_OUT.stb |-> !RD_WB_REQ_OUT.we && RD_WB_REQ_OUT.cti == CTI_CLASSIC
        && RD_WB_REQ_OUT.sel == SEL_ALL) else $error("read cycle not classic");
    rd_return_a: assert property (
        RD_WB_RSP_IN.ack |=> RD_DAT_VALID_OUT && RD_BUSY_OUT) else $error("read word lost");
    rd_hold_a: assert property (
        RD_DAT_VALID_OUT && !RD_DAT_READY_IN |=> RD_DAT_VALID_OUT && $stable(RD_DAT_OUT))
        else $error("read token dropped");
    wr_classic_a: assert property (
        WR_WB_REQ_OUT.stb |-> WR_WB_REQ_OUT.we && WR_WB_REQ_OUT.cyc
        && WR_WB_REQ_OUT.cti == CTI_CLASSIC) else $error("write cycle not classic");
    wr_pass_a: assert property (
        WR_TOK_VALID_IN |-> WR_WB_REQ_OUT.stb && WR_WB_REQ_OUT.adr == WR_TOK_IN.adr
        && WR_WB_REQ_OUT.dat == WR_TOK_IN.dat && WR_TOK_READY_OUT == !WR_WB_RSP_IN.stall)
        else $error("write token not passed");
    seq_take_a: assert property (
        SEQ_CMD_VALID_IN && SEQ_CMD_READY_OUT && SEQ_CNT_IN != 0 |=> SEQ_VAL_VALID_OUT
        && SEQ_VAL_OUT == (OFS_W > 0 ? $past(SEQ_OFS_IN) : '0)) else $error("bad first value");
    seq_step_a: assert property (
        s_next |-> SEQ_VAL_OUT == $past(SEQ_VAL_OUT) + 1'b1) else $error("value not +1");
    seq_hold_a: assert property (
        SEQ_VAL_VALID_OUT && !SEQ_VAL_READY_IN |=> SEQ_VAL_VALID_OUT && $stable(SEQ_VAL_OUT))
        else $error("value token dropped");
    seq_busy_a: assert property (
        SEQ_VAL_VALID_OUT |-> SEQ_BUSY_OUT && !SEQ_CMD_READY_OUT) else $error("busy wrong");
endmodule : dfa_top_chk
bind dfa_top dfa_top_chk #(.CNT_W(CNT_W), .OFS_W(OFS_W)) chk_u (.*);

//--- verification/testbench.sv
// Purpose: Self-checking bench for the dataflow bus actors.
// Assumes: 200 MHz clock, reset low for five cycles.
// Notes:   Offset-enabled unit, plus an offset-free twin fed the same inputs.
`timescale 1ns/1ps
// ****************************************************************
// Bench
// ****************************************************************
module testbench;
    import dfa_pkg::*;
    localparam int CNT_W = 8;
    localparam int OFS_W = 4;
    logic CLOCK_IN, RST_B_IN, RD_ADR_VALID_IN, RD_ADR_READY_OUT, RD_DAT_VALID_OUT;
    logic RD_DAT_READY_IN, WR_TOK_VALID_IN, WR_TOK_READY_OUT, SEQ_CMD_VALID_IN;
    logic SEQ_CMD_READY_OUT, SEQ_VAL_VALID_OUT, SEQ_VAL_READY_IN, rd_stall, wr_stall;
    logic RD_BUSY_OUT, WR_BUSY_OUT, SEQ_BUSY_OUT, seq0_valid;
    logic [ADR_W-1:0] RD_ADR_IN;
    logic [DAT_W-1:0] RD_DAT_OUT;
    logic [CNT_W-1:0] SEQ_CNT_IN;
    logic [OFS_W-1:0] SEQ_OFS_IN;
    logic [8:0]       SEQ_VAL_OUT;
    logic [CNT_W-1:0] seq0_val;
    logic [7:0]       wr_cnt;
    dfa_wb_req_t      RD_WB_REQ_OUT, WR_WB_REQ_OUT;
    dfa_wb_rsp_t      RD_WB_RSP_IN, WR_WB_RSP_IN;
    dfa_wr_tok_t      WR_TOK_IN, wr_last;
    int               err_count = 0;
    int               checks = 0;
    always #2.5 CLOCK_IN = ~CLOCK_IN;
    dfa_top #(.CNT_W(CNT_W), .OFS_W(OFS_W)) dut_u (.*);
    // Offset-free twin on shared inputs; its offset pin must be ignored
    dfa_top #(.CNT_W(CNT_W)) dut0_u (.CLOCK_IN(CLOCK_IN), .RST_B_IN(RST_B_IN),
        .RD_ADR_VALID_IN(RD_ADR_VALID_IN), .RD_ADR_READY_OUT(), .RD_ADR_IN(RD_ADR_IN),
        .RD_DAT_VALID_OUT(), .RD_DAT_READY_IN(RD_DAT_READY_IN), .RD_DAT_OUT(),
        .RD_WB_REQ_OUT(), .RD_WB_RSP_IN(RD_WB_RSP_IN), .WR_TOK_VALID_IN(WR_TOK_VALID_IN),
        .WR_TOK_READY_OUT(), .WR_TOK_IN(WR_TOK_IN), .WR_WB_REQ_OUT(),
        .WR_WB_RSP_IN(WR_WB_RSP_IN), .SEQ_CMD_VALID_IN(SEQ_CMD_VALID_IN),
        .SEQ_CMD_READY_OUT(), .SEQ_CNT_IN(SEQ_CNT_IN), .SEQ_OFS_IN(SEQ_OFS_IN[0]),
        .SEQ_VAL_VALID_OUT(seq0_valid), .SEQ_VAL_READY_IN(SEQ_VAL_READY_IN),
        .SEQ_VAL_OUT(seq0_val), .RD_BUSY_OUT(), .WR_BUSY_OUT(), .SEQ_BUSY_OUT());
    dfa_wb_slave_model rd_slv_u (.clk(CLOCK_IN), .rst_b(RST_B_IN), .stall_en(rd_stall),
        .req(RD_WB_REQ_OUT), .rsp(RD_WB_RSP_IN), .wr_cnt(), .wr_last());
    dfa_wb_slave_model wr_slv_u (.clk(CLOCK_IN), .rst_b(RST_B_IN), .stall_en(wr_stall),
        .req(WR_WB_REQ_OUT), .rsp(WR_WB_RSP_IN), .wr_cnt(wr_cnt), .wr_last(wr_last));
    task automatic end_sim;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    // Flag sampled just before each edge, so the edge itself transfers
    function automatic logic flag(input int k);
        case (k)
            0: return RD_ADR_READY_OUT;
            1: return RD_DAT_VALID_OUT;
            2: return WR_TOK_READY_OUT;
            3: return SEQ_CMD_READY_OUT;
            default: return SEQ_VAL_VALID_OUT;
        endcase
    endfunction : flag
    task automatic wait_acc(input int k);
        for (int n = 0; n < 200; n++) begin
            @(posedge CLOCK_IN);
            if (flag(k) === 1'b1) return;
        end
        $display("[FAIL] %0t: handshake timeout", $time);
        err_count++;
        end_sim();
    endtask : wait_acc
    // Stalled slave, then four back-to-back reads held in the buffer
    task automatic t_read;
        realtime t0;
        rd_stall <= 1'b1;
        RD_ADR_IN <= 30'h100;
        RD_ADR_VALID_IN <= 1'b1;
        repeat (3) begin
            @(posedge CLOCK_IN);
            check(RD_ADR_READY_OUT, 0);
        end
        rd_stall <= 1'b0;
        t0 = $realtime;
        for (int i = 0; i < 4; i++) begin
            RD_ADR_IN <= ADR_W'(i + 256);
            wait_acc(0);
        end
        check(int'(($realtime - t0) / 5.0), 4);
        RD_ADR_VALID_IN <= 1'b0;
        repeat (3) @(posedge CLOCK_IN);
        RD_DAT_READY_IN <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wait_acc(1);
            check(RD_DAT_OUT, {ADR_W'(i + 256), 2'b01});
        end
        RD_DAT_READY_IN <= 1'b0;
        @(posedge CLOCK_IN);
        check(RD_BUSY_OUT, 0);
    endtask : t_read
    // Writes refused under stall, then three back to back
    task automatic t_write;
        realtime t0;
        wr_stall <= 1'b1;
        WR_TOK_IN <= '{adr: 30'h20, dat: 32'hc0de0000};
        WR_TOK_VALID_IN <= 1'b1;
        repeat (2) begin
            @(posedge CLOCK_IN);
            check(WR_TOK_READY_OUT, 0);
        end
        wr_stall <= 1'b0;
        t0 = $realtime;
        for (int i = 0; i < 3; i++) begin
            WR_TOK_IN <= '{adr: ADR_W'(i + 32), dat: DAT_W'(i) + 32'hc0de0000};
            wait_acc(2);
        end
        check(int'(($realtime - t0) / 5.0), 3);
        WR_TOK_VALID_IN <= 1'b0;
        repeat (2) @(posedge CLOCK_IN);
        check(wr_cnt, 3);
        check(wr_last, {30'h22, 32'hc0de0002});
        check(WR_BUSY_OUT, 0);
    endtask : t_write
    // One command, first value held two cycles, then all values drained
    task automatic t_seq(input int n, input int o);
        SEQ_CNT_IN <= CNT_W'(n);
        SEQ_OFS_IN <= OFS_W'(o);
        SEQ_CMD_VALID_IN <= 1'b1;
        wait_acc(3);
        SEQ_CMD_VALID_IN <= 1'b0;
        repeat (2) @(posedge CLOCK_IN);
        if (n > 0)
            SEQ_VAL_READY_IN <= 1'b1;
        for (int i = 0; i < n; i++) begin
            wait_acc(4);
            check(SEQ_VAL_OUT, 9'(o + i));
            check({seq0_valid, seq0_val}, {1'b1, CNT_W'(i)});
        end
        SEQ_VAL_READY_IN <= 1'b0;
        @(posedge CLOCK_IN);
        check({SEQ_CMD_READY_OUT, SEQ_BUSY_OUT}, 2'b10);
        check({SEQ_VAL_VALID_OUT, seq0_valid}, 2'b00);
    endtask : t_seq
    initial begin
        {CLOCK_IN, RST_B_IN, RD_ADR_VALID_IN, RD_DAT_READY_IN, rd_stall, wr_stall} = '0;
        {WR_TOK_VALID_IN, SEQ_CMD_VALID_IN, SEQ_VAL_READY_IN} = '0;
        {RD_ADR_IN, WR_TOK_IN, SEQ_CNT_IN, SEQ_OFS_IN} = '0;
        repeat (5) @(posedge CLOCK_IN);
        RST_B_IN <= 1'b1;
        @(posedge CLOCK_IN);
        t_read();
        t_write();
        t_seq(3, 0);
        t_seq(4, 5);
        t_seq(2, 15);
        t_seq(0, 0);
        end_sim();
    end
endmodule : testbench
